// ---- rtl/pced_pkg.sv ----
// Shared constants, types and helper functions of the pin change detector.
package pced_pkg;

	// ----------------------------------------------------------------
	// Sizes and register map
	// ----------------------------------------------------------------
	localparam int PCED_PINS = 8;
	localparam int PCED_AW = 8;
	localparam logic [PCED_AW-1:0] OFF_RISE_EN = 8'h00;
	localparam logic [PCED_AW-1:0] OFF_FALL_EN = 8'h04;
	localparam logic [PCED_AW-1:0] OFF_FLAGS = 8'h08;
	localparam logic [PCED_AW-1:0] OFF_CTRL = 8'h0C;
	localparam logic [PCED_AW-1:0] OFF_IRQ_STAT = 8'h10;
	localparam logic [PCED_AW-1:0] OFF_IRQ_CLR = 8'h14;
	localparam logic [PCED_AW-1:0] OFF_IRQ_EN = 8'h18;

	// ----------------------------------------------------------------
	// Field positions, reset values and responses
	// ----------------------------------------------------------------
	localparam int CTRL_MASTER_BIT = 0;
	localparam int CTRL_SUMMARY_BIT = 1;
	localparam int IRQ_CHANGE_BIT = 0;
	localparam int IRQ_WAKE_BIT = 1;
	localparam int IRQ_W = 2;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [IRQ_W-1:0] IRQ_RESET = 2'h0;
	localparam logic [23:0] RD_PAD = 24'h000000;
	localparam logic [29:0] CTRL_PAD = 30'h00000000;
	localparam logic [31:0] RD_ZERO = 32'h00000000;
	localparam logic [PCED_AW-1:0] ADDR_RESET = 8'h00;
	localparam logic [3:0] STRB_RESET = 4'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef logic [PCED_PINS-1:0] pced_pins_t;

	typedef struct packed {
		pced_pins_t riseEn;
		pced_pins_t fallEn;
	} pced_cfg_s;

	typedef struct packed {
		pced_pins_t rise;
		pced_pins_t fall;
	} pced_edges_s;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	// True when a byte address selects the word at the given offset.
	function automatic logic regHit(input logic [PCED_AW-1:0] a,
			input logic [PCED_AW-1:0] off);
		regHit = (a[PCED_AW-1:2] == off[PCED_AW-1:2]);
	endfunction

	// Next value of a sticky register: a write replaces, a set wins.
	function automatic pced_pins_t stickyNext(input pced_pins_t cur,
			input logic wr, input pced_pins_t val, input pced_pins_t set);
		stickyNext = (wr ? val : cur) | set;
	endfunction

endpackage

// ---- rtl/pced_sync.sv ----
// Two-stage synchroniser for the eight port pins.
`timescale 1ns/100ps
`default_nettype none
module pced_sync import pced_pkg::*; (
	input wire logic ref_clk, // System clock.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire pced_pins_t pinAsync, // Raw port pins.
	output wire pced_pins_t pinSync // Pins on the clock domain.
);
	pced_pins_t meta_q;
	pced_pins_t stable_q;

	// The first stage feeds only the second stage.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			meta_q <= REG_RESET;
			stable_q <= REG_RESET;
		end else begin
			meta_q <= pinAsync;
			stable_q <= meta_q;
		end
	end

	assign pinSync = stable_q;
endmodule
`default_nettype wire

// ---- rtl/pced_edge.sv ----
// Per-pin rising and falling edge detectors with their enables.
`timescale 1ns/100ps
`default_nettype none
module pced_edge import pced_pkg::*; (
	input wire logic ref_clk, // System clock.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire pced_pins_t pinSync, // Synchronised pins.
	input wire pced_cfg_s cfg, // Edge enables.
	output wire pced_edges_s edges, // Enabled edges this cycle.
	output wire logic primed // Previous sample is valid.
);
	pced_pins_t prev_q;
	logic primed_q;

	// Keeps the last sample; the first one after reset only primes it.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			prev_q <= REG_RESET;
			primed_q <= 1'b0;
		end else begin
			prev_q <= pinSync;
			primed_q <= 1'b1;
		end
	end

	// Two consecutive samples are compared, each direction gated.
	assign edges.rise = primed_q ? (pinSync & ~prev_q & cfg.riseEn) :
		REG_RESET;
	assign edges.fall = primed_q ? (~pinSync & prev_q & cfg.fallEn) :
		REG_RESET;
	assign primed = primed_q;
endmodule
`default_nettype wire

// ---- rtl/pced_top.sv ----
// Pin change edge detector with its AXI4-Lite register slave.
//
// Notes on behaviour
// - Per-pin rising detector, armed by its enable.
// - Per-pin falling detector, armed by its enable.
// - Both enables set detect either direction.
// - Enabled edge sets pin flag until cleared.
// - Flags still set while master enable off.
// - Summary is OR of flags; gates request.
// - Writing zero clears a flag.
// - Edge during flag write keeps flag set.
// - Enabled edge wakes device when master set.
// - Flags updated in the same cycle wake is signalled.
// - Enables and flags reset to zero.
`timescale 1ns/100ps
`default_nettype none
module pced_top import pced_pkg::*; (
	input wire logic ref_clk, // System clock, 100 MHz.
	input wire logic reset_n, // Asynchronous reset, active low.
	input wire pced_pins_t portPin, // Port pins from outside.
	input wire logic sleepMode, // Core is asleep.
	input wire logic [PCED_AW-1:0] s_axi_awaddr, // Write address.
	input wire logic s_axi_awvalid, // Write address valid.
	output wire logic s_axi_awready, // Write address ready.
	input wire logic [31:0] s_axi_wdata, // Write data.
	input wire logic [3:0] s_axi_wstrb, // Write byte strobes.
	input wire logic s_axi_wvalid, // Write data valid.
	output wire logic s_axi_wready, // Write data ready.
	output wire logic [1:0] s_axi_bresp, // Write response.
	output wire logic s_axi_bvalid, // Write response valid.
	input wire logic s_axi_bready, // Write response ready.
	input wire logic [PCED_AW-1:0] s_axi_araddr, // Read address.
	input wire logic s_axi_arvalid, // Read address valid.
	output wire logic s_axi_arready, // Read address ready.
	output wire logic [31:0] s_axi_rdata, // Read data.
	output wire logic [1:0] s_axi_rresp, // Read response.
	output wire logic s_axi_rvalid, // Read data valid.
	input wire logic s_axi_rready, // Read data ready.
	output wire logic changeIrq, // Change request to the core.
	output wire logic summaryFlag, // OR of all pin flags.
	output wire logic wakeReq, // Wake pulse out of sleep.
	output wire logic irq // Status interrupt line.
);

	// ----------------------------------------------------------------
	// Declarations
	// ----------------------------------------------------------------
	pced_pins_t pinSync;
	pced_edges_s edges;
	pced_cfg_s cfg;
	logic primed;
	pced_pins_t edgeHit;
	pced_pins_t riseEn_q, fallEn_q, flags_q, flags_d;
	logic masterEn_q, masterEn_d;
	logic [IRQ_W-1:0] irqStat_q, irqStat_d, irqEn_q, irqEvents;
	logic changeIrq_q, summary_q, wakeReq_q, irq_q;
	logic awReady_q, awReady_d, wReady_q, wReady_d;
	logic awHeld_q, awHeld_d, wHeld_q, wHeld_d;
	logic [PCED_AW-1:0] awAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic bValid_q, bValid_d, arReady_q, arReady_d, rValid_q, rValid_d;
	logic [1:0] bResp_q, rResp_q;
	logic [31:0] rData_q, rdWord;
	logic awTake, wTake, arTake, doWrite, wrLane, wrMapped, rdMapped;
	logic wrRise, wrFall, wrFlags, wrCtrl, wrIrqClr, wrIrqEn;
	pced_pins_t wrByte;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	// ----------------------------------------------------------------
	// Pin path
	// ----------------------------------------------------------------
	// Pins pass two flops before the detectors compare samples.
	pced_sync u_sync (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinAsync(portPin),
		.pinSync(pinSync)
	);

	assign cfg.riseEn = riseEn_q;
	assign cfg.fallEn = fallEn_q;

	pced_edge u_edge (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.pinSync(pinSync),
		.cfg(cfg),
		.edges(edges),
		.primed(primed)
	);

	// Any enabled direction counts as a detected change.
	assign edgeHit = edges.rise | edges.fall;

	// ----------------------------------------------------------------
	// AXI4-Lite handshakes
	// ----------------------------------------------------------------
	// Address and data are taken in either order and held until used.
	assign awTake = s_axi_awvalid & awReady_q;
	assign wTake = s_axi_wvalid & wReady_q;
	assign arTake = s_axi_arvalid & arReady_q;
	assign doWrite = awHeld_q & wHeld_q & ~bValid_q;
	assign awHeld_d = awTake | (awHeld_q & ~doWrite);
	assign wHeld_d = wTake | (wHeld_q & ~doWrite);
	assign bValid_d = doWrite | (bValid_q & ~s_axi_bready);
	assign awReady_d = ~awHeld_d & ~bValid_d;
	assign wReady_d = ~wHeld_d & ~bValid_d;
	assign rValid_d = arTake | (rValid_q & ~s_axi_rready);
	assign arReady_d = ~rValid_d;

	// Write decode; registers live in byte lane zero.
	assign wrLane = doWrite & wStrb_q[0];
	assign wrByte = wData_q[PCED_PINS-1:0];
	assign wrRise = wrLane & regHit(awAddr_q, OFF_RISE_EN);
	assign wrFall = wrLane & regHit(awAddr_q, OFF_FALL_EN);
	assign wrFlags = wrLane & regHit(awAddr_q, OFF_FLAGS);
	assign wrCtrl = wrLane & regHit(awAddr_q, OFF_CTRL);
	assign wrIrqClr = wrLane & regHit(awAddr_q, OFF_IRQ_CLR);
	assign wrIrqEn = wrLane & regHit(awAddr_q, OFF_IRQ_EN);
	assign wrMapped = regHit(awAddr_q, OFF_RISE_EN) |
		regHit(awAddr_q, OFF_FALL_EN) | regHit(awAddr_q, OFF_FLAGS) |
		regHit(awAddr_q, OFF_CTRL) | regHit(awAddr_q, OFF_IRQ_STAT) |
		regHit(awAddr_q, OFF_IRQ_CLR) | regHit(awAddr_q, OFF_IRQ_EN);

	// Read selection; the clear register reads as zero.
	assign rdWord = regHit(s_axi_araddr, OFF_RISE_EN) ? {RD_PAD, riseEn_q} :
		regHit(s_axi_araddr, OFF_FALL_EN) ? {RD_PAD, fallEn_q} :
		regHit(s_axi_araddr, OFF_FLAGS) ? {RD_PAD, flags_q} :
		regHit(s_axi_araddr, OFF_CTRL) ? {CTRL_PAD, summary_q, masterEn_q} :
		regHit(s_axi_araddr, OFF_IRQ_STAT) ? {RD_ZERO[31:IRQ_W], irqStat_q} :
		regHit(s_axi_araddr, OFF_IRQ_EN) ? {RD_ZERO[31:IRQ_W], irqEn_q} :
		RD_ZERO;
	assign rdMapped = regHit(s_axi_araddr, OFF_RISE_EN) |
		regHit(s_axi_araddr, OFF_FALL_EN) | regHit(s_axi_araddr, OFF_FLAGS) |
		regHit(s_axi_araddr, OFF_CTRL) | regHit(s_axi_araddr, OFF_IRQ_STAT) |
		regHit(s_axi_araddr, OFF_IRQ_CLR) | regHit(s_axi_araddr, OFF_IRQ_EN);

	// Bus channel state.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			awReady_q <= 1'b0;
			wReady_q <= 1'b0;
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			bValid_q <= 1'b0;
			arReady_q <= 1'b0;
			rValid_q <= 1'b0;
		end else begin
			awReady_q <= awReady_d;
			wReady_q <= wReady_d;
			awHeld_q <= awHeld_d;
			wHeld_q <= wHeld_d;
			bValid_q <= bValid_d;
			arReady_q <= arReady_d;
			rValid_q <= rValid_d;
		end
	end

	// Bus payload registers.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			awAddr_q <= ADDR_RESET;
			wData_q <= RD_ZERO;
			wStrb_q <= STRB_RESET;
			bResp_q <= RESP_OKAY;
			rData_q <= RD_ZERO;
			rResp_q <= RESP_OKAY;
		end else begin
			if (awTake) begin
				awAddr_q <= s_axi_awaddr;
			end
			if (wTake) begin
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
			end
			if (doWrite) begin
				bResp_q <= wrMapped ? RESP_OKAY : RESP_SLVERR;
			end
			if (arTake) begin
				rData_q <= rdWord;
				rResp_q <= rdMapped ? RESP_OKAY : RESP_SLVERR;
			end
		end
	end

	// ----------------------------------------------------------------
	// Change detection registers
	// ----------------------------------------------------------------
	// A write replaces the flags, but a new edge always wins.
	assign flags_d = stickyNext(flags_q, wrFlags, wrByte, edgeHit);
	assign masterEn_d = wrCtrl ? wrByte[CTRL_MASTER_BIT] : masterEn_q;

	// Events: an enabled change while the master is on, and a wake.
	assign irqEvents[IRQ_CHANGE_BIT] = masterEn_q & (|edgeHit);
	assign irqEvents[IRQ_WAKE_BIT] = sleepMode & masterEn_q & (|edgeHit);
	assign irqStat_d = (wrIrqClr ? (irqStat_q & ~wrByte[IRQ_W-1:0]) :
		irqStat_q) | irqEvents;

	// Enables, flags and master switch; all clear on reset.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			riseEn_q <= REG_RESET;
			fallEn_q <= REG_RESET;
			flags_q <= REG_RESET;
			masterEn_q <= 1'b0;
		end else begin
			if (wrRise) begin
				riseEn_q <= wrByte;
			end
			if (wrFall) begin
				fallEn_q <= wrByte;
			end
			flags_q <= flags_d;
			masterEn_q <= masterEn_d;
		end
	end

	// Request lines follow the next flag value so they never lag it.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			summary_q <= 1'b0;
			changeIrq_q <= 1'b0;
			wakeReq_q <= 1'b0;
			irqStat_q <= IRQ_RESET;
			irqEn_q <= IRQ_RESET;
			irq_q <= 1'b0;
		end else begin
			summary_q <= |flags_d;
			changeIrq_q <= (|flags_d) & masterEn_d;
			wakeReq_q <= irqEvents[IRQ_WAKE_BIT];
			irqStat_q <= irqStat_d;
			if (wrIrqEn) begin
				irqEn_q <= wrByte[IRQ_W-1:0];
			end
			irq_q <= |(irqStat_q & irqEn_q);
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = awReady_q;
	assign s_axi_wready = wReady_q;
	assign s_axi_bresp = bResp_q;
	assign s_axi_bvalid = bValid_q;
	assign s_axi_arready = arReady_q;
	assign s_axi_rdata = rData_q;
	assign s_axi_rresp = rResp_q;
	assign s_axi_rvalid = rValid_q;
	assign changeIrq = changeIrq_q;
	assign summaryFlag = summary_q;
	assign wakeReq = wakeReq_q;
	assign irq = irq_q;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	sequence s_edgeInWrite;
		wrFlags && (|edgeHit);
	endsequence

	sequence s_wakeCause;
		sleepMode && masterEn_q && (|edgeHit);
	endsequence

	a_rise_gate: assert property (
		primed |-> edges.rise == (pinSync & ~$past(pinSync) & riseEn_q))
		else $error("Rising detection does not match enable.");
	a_fall_gate: assert property (
		primed |-> edges.fall == (~pinSync & $past(pinSync) & fallEn_q))
		else $error("Falling detection does not match enable.");
	a_both_dirs: assert property (primed |-> ((pinSync ^
		$past(pinSync)) & riseEn_q & fallEn_q & ~edgeHit) == REG_RESET)
		else $error("Change missed with both directions enabled.");
	a_flag_sticky: assert property ((|flags_q) && !wrFlags |=>
		(flags_q & $past(flags_q)) == $past(flags_q))
		else $error("Pin flag dropped without a write.");
	a_flag_one_cycle: assert property (
		!masterEn_q && (|edgeHit) |=> (flags_q & $past(edgeHit)) ==
		$past(edgeHit)) else $error("Edge did not set its flag next cycle.");
	a_write_clears: assert property (wrFlags |=>
		flags_q == ($past(wrByte) | $past(edgeHit)))
		else $error("Flag write gave the wrong value.");
	a_set_wins: assert property (s_edgeInWrite |=>
		(flags_q & $past(edgeHit)) == $past(edgeHit))
		else $error("Edge lost during a flag write.");
	a_summary_or: assert property (summary_q == (|flags_q))
		else $error("Summary flag is not the OR of flags.");
	a_req_gated: assert property (changeIrq_q ==
		(summary_q && masterEn_q))
		else $error("Change request not gated by master.");
	a_wake_edge: assert property (s_wakeCause |=>
		wakeReq_q && summary_q &&
		((flags_q & $past(edgeHit)) == $past(edgeHit)))
		else $error("Wake missing or flags not ready at wake.");
	a_irq_line: assert property (##1 irq_q == // Status interrupt line.
		$past(|(irqStat_q & irqEn_q)))
		else $error("Interrupt line does not follow status.");
endmodule
`default_nettype wire

// ---- bench/pced_far_model.sv ----
// Far side model: port pin source and a core that sleeps and wakes.
`timescale 1ns/100ps
`default_nettype none
module pced_far_model import pced_pkg::*; (
	input wire logic ref_clk, // System clock.
	input wire logic reset_n, // Reset, active low.
	input wire pced_pins_t target, // Pin levels to present.
	input wire logic [3:0] lag, // Cycles before pins follow.
	input wire logic goSleep, // Core enters sleep.
	input wire logic wakeReq, // Wake pulse from the block.
	output var pced_pins_t portPin = 8'h00, // Port pins.
	output var logic sleepMode // Core is asleep.
);
	// Pins follow the target late and off the edge, as a real source does.
	always begin
		@(target);
		repeat (lag) @(posedge ref_clk);
		#2 portPin = target;
	end

	// The core sleeps on request and leaves sleep on a wake pulse.
	always_ff @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			sleepMode <= 1'h0;
		end else if (wakeReq) begin
			sleepMode <= 1'h0;
		end else if (goSleep) begin
			sleepMode <= 1'h1;
		end
	end
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
// Self-checking testbench of the pin change edge detector.
`timescale 1ns/100ps
`default_nettype none
module tb_top import pced_pkg::*; ;
	typedef struct packed {
		pced_pins_t r, f, a, b, x;
	} pced_row_s;
	pced_row_s rows [5] = '{'{8'hFF, 8'h00, 8'h00, 8'hFF, 8'hFF},
		'{8'hFF, 8'h00, 8'hFF, 8'h00, 8'h00},
		'{8'h00, 8'h0F, 8'hFF, 8'h00, 8'h0F},
		'{8'h00, 8'h00, 8'h00, 8'hFF, 8'h00},
		'{8'hA5, 8'hA5, 8'h0F, 8'hF0, 8'hA5}};
	logic ref_clk, reset_n, goSleep, sleepMode;
	pced_pins_t target, portPin;
	logic [3:0] lag;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp, r;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready, changeIrq, summaryFlag, wakeReq, irq;
	int fail_count = 0, n_tests = 0, wakeCnt = 0, w0, i;

	pced_far_model far (.ref_clk(ref_clk), .reset_n(reset_n),
		.target(target), .lag(lag), .goSleep(goSleep), .wakeReq(wakeReq),
		.portPin(portPin), .sleepMode(sleepMode));
	pced_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .portPin(portPin),
		.sleepMode(sleepMode), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.changeIrq(changeIrq), .summaryFlag(summaryFlag),
		.wakeReq(wakeReq), .irq(irq));

	// Clock and a count of wake pulses.
	initial begin
		ref_clk = 1'h0;
		forever #5 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		if (wakeReq === 1'h1) wakeCnt <= wakeCnt + 1;
	end

	// ----------------------------------------------------------------
	// Checking and bus tasks
	// ----------------------------------------------------------------
	task automatic results;
		if (fail_count == 0 && n_tests > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// One write; address and data are released as each is taken.
	task automatic wrReg(input logic [7:0] a, input logic [31:0] v);
		int k;
		logic aw, w;
		@(posedge ref_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		aw = 1'h0;
		w = 1'h0;
		for (k = 0; k < 50; k++) begin
			@(posedge ref_clk);
			if (!aw && s_axi_awready) begin
				aw = 1'h1;
				s_axi_awvalid <= 1'h0;
			end
			if (!w && s_axi_wready) begin
				w = 1'h1;
				s_axi_wvalid <= 1'h0;
			end
			if (s_axi_bvalid) begin
				r = s_axi_bresp;
				s_axi_bready <= 1'h0;
				break;
			end
		end
		if (k == 50) begin
			fail_count++;
			results();
		end
	endtask

	// One read, answer taken at the edge where rvalid is seen.
	task automatic rdReg(input logic [7:0] a);
		int k;
		@(posedge ref_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= 1'h1;
		for (k = 0; k < 50; k++) begin
			@(posedge ref_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid) begin
				d = s_axi_rdata;
				r = s_axi_rresp;
				s_axi_rready <= 1'h0;
				break;
			end
		end
		if (k == 50) begin
			fail_count++;
			results();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		wrReg(a, {RD_PAD, v});
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask

	task automatic rdChk(input logic [7:0] a, input logic [7:0] v);
		rdReg(a);
		chk(d, {RD_PAD, v});
		chk({30'h0, r}, {30'h0, RESP_OKAY});
	endtask

	// Clears only the known flags from a fresh read.
	task automatic clr(input logic [7:0] known);
		rdReg(OFF_FLAGS);
		wr(OFF_FLAGS, d[7:0] & ~known);
	endtask

	task automatic pins(input pced_pins_t v);
		@(posedge ref_clk);
		target <= v;
		repeat (9) @(posedge ref_clk);
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		{reset_n, goSleep, s_axi_awvalid, s_axi_wvalid} = 4'h0;
		{s_axi_bready, s_axi_arvalid, s_axi_rready} = 3'h0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
		s_axi_wstrb = 4'hF;
		target = 8'h00;
		lag = 4'h2;
		repeat (10) @(posedge ref_clk);
		reset_n <= 1'h1;
		rdChk(OFF_RISE_EN, 8'h00);
		rdChk(OFF_FALL_EN, 8'h00);
		rdChk(OFF_FLAGS, 8'h00);
		for (i = 0; i < 5; i++) begin
			wr(OFF_RISE_EN, 8'h00);
			wr(OFF_FALL_EN, 8'h00);
			pins(rows[i].a);
			wr(OFF_RISE_EN, rows[i].r);
			wr(OFF_FALL_EN, rows[i].f);
			wr(OFF_FLAGS, 8'h00);
			pins(rows[i].b);
			rdChk(OFF_FLAGS, rows[i].x);
			chk({31'h0, summaryFlag}, {31'h0, |rows[i].x});
		end
		// Flag timing and the master enable.
		lag = 4'h0;
		wr(OFF_RISE_EN, 8'h01);
		wr(OFF_FALL_EN, 8'h00);
		clr(8'hFF);
		@(posedge ref_clk);
		target <= 8'hF1;
		tick(1);
		chk({31'h0, summaryFlag}, 32'h0);
		tick(4);
		chk({31'h0, summaryFlag}, 32'h1);
		chk({31'h0, changeIrq}, 32'h0);
		wr(OFF_CTRL, 8'h01);
		tick(2);
		chk({31'h0, changeIrq}, 32'h1);
		rdChk(OFF_CTRL, 8'h03);
		clr(8'h01);
		tick(2);
		chk({30'h0, summaryFlag, changeIrq}, 32'h0);
		// Status, enable and clear of the interrupt line.
		pins(8'hF0);
		pins(8'hF1);
		rdChk(OFF_IRQ_STAT, 8'h01);
		chk({31'h0, irq}, 32'h0);
		wr(OFF_IRQ_EN, 8'h03);
		tick(2);
		chk({31'h0, irq}, 32'h1);
		wr(OFF_IRQ_STAT, 8'h00);
		rdChk(OFF_IRQ_STAT, 8'h01);
		wr(OFF_IRQ_CLR, 8'h03);
		tick(2);
		chk({31'h0, irq}, 32'h0);
		rdChk(OFF_IRQ_STAT, 8'h00);
		rdChk(OFF_IRQ_CLR, 8'h00);
		@(posedge ref_clk);
		s_axi_wstrb <= 4'hE;
		wr(OFF_RISE_EN, 8'hFF);
		s_axi_wstrb <= 4'hF;
		rdChk(OFF_RISE_EN, 8'h01);
		wrReg(8'h1C, 32'h0000_00FF);
		chk({30'h0, r}, {30'h0, RESP_SLVERR});
		rdReg(8'h1C);
		chk({d[29:0], r}, {30'h0, RESP_SLVERR});
		// Sleep with the master off, then on.
		clr(8'hFF);
		wr(OFF_CTRL, 8'h00);
		@(posedge ref_clk);
		goSleep <= 1'h1;
		@(posedge ref_clk);
		goSleep <= 1'h0;
		w0 = wakeCnt;
		pins(8'hF0);
		pins(8'hF1);
		chk(wakeCnt - w0, 32'h0);
		chk({30'h0, sleepMode, summaryFlag}, 32'h3);
		clr(8'h01);
		wr(OFF_CTRL, 8'h01);
		pins(8'hF0);
		@(posedge ref_clk);
		target <= 8'hF1;
		for (i = 0; i < 20 && wakeReq !== 1'h1; i++) tick(1);
		chk({31'h0, wakeReq}, 32'h1);
		chk({31'h0, summaryFlag}, 32'h1);
		tick(2);
		chk({31'h0, sleepMode}, 32'h0);
		rdChk(OFF_IRQ_STAT, 8'h03);
		// A clearing write while pin 0 toggles every cycle.
		wr(OFF_RISE_EN, 8'h03);
		wr(OFF_FALL_EN, 8'h01);
		pins(8'hF3);
		fork
			repeat (60) begin
				@(posedge ref_clk);
				target <= target ^ 8'h01;
			end
		join_none
		repeat (4) @(posedge ref_clk);
		wr(OFF_FLAGS, 8'h00);
		rdChk(OFF_FLAGS, 8'h01);
		wait fork;
		// A second reset in mid-run.
		@(posedge ref_clk);
		reset_n <= 1'h0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'h1;
		rdChk(OFF_RISE_EN, 8'h00);
		rdChk(OFF_FALL_EN, 8'h00);
		rdChk(OFF_FLAGS, 8'h00);
		chk({31'h0, summaryFlag}, 32'h0);
		results();
	end
endmodule
`default_nettype wire
